// File: logic/acc_pkg.sv
// Package: register map, field layout, reset values and timing for the converter control block
package acc_pkg;

	// Register word addresses (byte addresses, one aligned 32-bit word each)
	localparam logic [7:0] ADDR_CFG      = 8'h00;
	localparam logic [7:0] ADDR_CONVERT  = 8'h04;
	localparam logic [7:0] ADDR_TEMP     = 8'h08;
	localparam logic [7:0] ADDR_DATA     = 8'h0c;
	localparam logic [7:0] ADDR_FLAG     = 8'h10;
	localparam logic [7:0] ADDR_TOUCH    = 8'h14;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
	localparam logic [7:0] ADDR_IRQ_EN   = 8'h1c;
	localparam logic [7:0] ADDR_IRQ_CLR  = 8'h20;

	// Configuration fields
	localparam int CFG_DIV_HI  = 7;
	localparam int CFG_DIV_LO  = 6;
	localparam int CFG_GAIN_HI = 5;
	localparam int CFG_GAIN_LO = 4;
	localparam int CFG_OFS     = 3;
	localparam int CFG_DIFF    = 2;
	localparam int CFG_BUF     = 1;
	localparam int CFG_PWR     = 0;
	localparam logic [7:0] CFG_RESET = 8'ha0;

	// Conversion control, temperature, flag fields
	localparam int CONV_EOC  = 7;
	localparam int CONV_GO   = 0;
	localparam int TEMP_PWR  = 7;
	localparam int FLAG_EOC  = 7;
	localparam int RES_W     = 12;
	localparam logic [11:0] RES_INV_MASK = 12'hfff;

	// Interrupt status bits
	localparam int IRQ_DONE = 0;
	localparam int IRQ_W    = 1;

	// Divider codes: base clock divided by 10, 4, 6, 8
	localparam logic [1:0] DIV_CODE_10 = 2'h0;
	localparam logic [1:0] DIV_CODE_4  = 2'h1;
	localparam logic [1:0] DIV_CODE_6  = 2'h2;
	localparam logic [1:0] DIV_CODE_8  = 2'h3;
	localparam logic [3:0] DIV_10 = 4'ha;
	localparam logic [3:0] DIV_4  = 4'h4;
	localparam logic [3:0] DIV_6  = 4'h6;
	localparam logic [3:0] DIV_8  = 4'h8;

	// Conversion phases in converter clocks
	localparam logic [4:0] SAMPLE_CLKS = 5'h04;
	localparam logic [4:0] SWITCH_CLKS = 5'h01;
	localparam logic [4:0] CONV_CLKS   = 5'h0c;
	localparam logic [4:0] TOTAL_CLKS  = SAMPLE_CLKS + SWITCH_CLKS + CONV_CLKS;

	// Base clock from a 125 MHz system clock: fractional accumulator
	localparam int SYS_MHZ  = 125;
	localparam int BASE_MHZ = 32;
	localparam logic [7:0] BASE_INC = 8'(BASE_MHZ);
	localparam logic [7:0] BASE_MOD = 8'(SYS_MHZ);

	typedef enum logic [1:0] {
		ACC_IDLE,
		ACC_SAMPLE,
		ACC_CONVERT
	} acc_state_e;

endpackage

// File: logic/acc_core_if.sv
// Interface: control and result lines between the register block and the sequencer
`timescale 1ns/1ps
`default_nettype none
interface acc_core_if;
	logic        start;
	logic        power;
	logic [1:0]  div_sel;
	logic        busy;
	logic        done;
	logic [11:0] result;

	modport ctrl (output start, output power, output div_sel,
		input busy, input done, input result);
	modport seq (input start, input power, input div_sel,
		output busy, output done, output result);
endinterface
`default_nettype wire

// File: logic/acc_seq.sv
// Converter clock divider and conversion sequencer facing the analog core
`timescale 1ns/1ps
`default_nettype none
module acc_seq (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	acc_core_if.seq          cif,
	input  wire logic [11:0] core_result_i,
	output logic             core_sample_o,
	output logic             core_tick_o
);
	logic [7:0]        acc_r;
	logic              base_tick;
	logic [3:0]        div_cnt_r;
	logic [3:0]        div_max;
	logic              adc_tick;
	logic [4:0]        phase_r;
	acc_pkg::acc_state_e state_r;

	// 32 MHz base rate as an enable pulse, average exact over 125 cycles
	always_ff @(posedge clk_i) begin
		if (rst_i)
			acc_r <= '0;
		else if (acc_r + acc_pkg::BASE_INC >= acc_pkg::BASE_MOD)
			acc_r <= 8'(acc_r + acc_pkg::BASE_INC - acc_pkg::BASE_MOD);
		else
			acc_r <= 8'(acc_r + acc_pkg::BASE_INC);
	end
	assign base_tick = (acc_r + acc_pkg::BASE_INC >= acc_pkg::BASE_MOD);

	always_comb begin
		case (cif.div_sel)
			acc_pkg::DIV_CODE_10: div_max = acc_pkg::DIV_10;
			acc_pkg::DIV_CODE_4:  div_max = acc_pkg::DIV_4;
			acc_pkg::DIV_CODE_6:  div_max = acc_pkg::DIV_6;
			acc_pkg::DIV_CODE_8:  div_max = acc_pkg::DIV_8;
			default:              div_max = acc_pkg::DIV_6;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			div_cnt_r <= '0;
		else if (base_tick)
			div_cnt_r <= (div_cnt_r >= 4'(div_max - 4'h1)) ? 4'h0 : 4'(div_cnt_r + 4'h1);
	end
	assign adc_tick = base_tick && (div_cnt_r >= 4'(div_max - 4'h1));

	// Seventeen converter clocks per conversion; about 1/18 with restart
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= acc_pkg::ACC_IDLE;
			phase_r <= '0;
		end else begin
			case (state_r)
				acc_pkg::ACC_IDLE: begin
					phase_r <= '0;
					if (cif.start && cif.power)
						state_r <= acc_pkg::ACC_SAMPLE;
				end
				acc_pkg::ACC_SAMPLE: begin
					if (!cif.power)
						state_r <= acc_pkg::ACC_IDLE;
					else if (adc_tick) begin
						phase_r <= 5'(phase_r + 5'h01);
						if (phase_r == 5'(acc_pkg::SAMPLE_CLKS + acc_pkg::SWITCH_CLKS - 5'h01))
							state_r <= acc_pkg::ACC_CONVERT;
					end
				end
				acc_pkg::ACC_CONVERT: begin
					if (!cif.power)
						state_r <= acc_pkg::ACC_IDLE;
					else if (adc_tick) begin
						phase_r <= 5'(phase_r + 5'h01);
						if (phase_r == 5'(acc_pkg::TOTAL_CLKS - 5'h01))
							state_r <= acc_pkg::ACC_IDLE;
					end
				end
				default: state_r <= acc_pkg::ACC_IDLE;
			endcase
		end
	end

	// Result is captured by the register block on the done pulse
	assign cif.done   = cif.power && state_r == acc_pkg::ACC_CONVERT && adc_tick
		&& phase_r == 5'(acc_pkg::TOTAL_CLKS - 5'h01);
	assign cif.busy   = state_r != acc_pkg::ACC_IDLE;
	assign cif.result = core_result_i;
	assign core_sample_o = state_r == acc_pkg::ACC_SAMPLE && phase_r < acc_pkg::SAMPLE_CLKS;
	assign core_tick_o   = adc_tick;
endmodule
`default_nettype wire

// File: logic/acc_top.sv
// What this block does
// - Clock select divides base by 10,4,6,8
// - Conversion rate about one eighteenth of clock
// - Gain field selects quarter, half, unity, double
// - Offset test inverts twelve result bits
// - Bit 2 selects differential input
// - Bit 1 enables input buffer
// - Bit 0 powers the converter
// - End-of-conversion status from asynchronous source
// - Writing start begins conversion; self-clearing
// - Temperature sensor power bit, reserved bits kept
// - Result in bits 11:0, upper reserved
// - Finished flag cleared by control writes
// - Four sample, one switch, twelve convert clocks
`timescale 1ns/1ps
`default_nettype none
module acc_top (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        core_eoc_async_i,
	input  wire logic [11:0] core_result_i,
	output logic             core_sample_o,
	output logic             core_tick_o,
	output logic [1:0]       front_end_gain_select_o,
	output logic             differential_input_enable_o,
	output logic             input_buffer_enable_o,
	output logic             converter_power_enable_o,
	output logic             temp_sensor_power_enable_o,
	output logic             irq_o
);
	acc_core_if cif ();

	localparam int IRQ_W_C = acc_pkg::IRQ_W;

	logic [7:0]  cfg_r;
	logic        start_r;
	logic [6:0]  temp_rsv_r;
	logic        temp_pwr_r;
	logic [3:0]  data_rsv_r;
	logic [11:0] result_r;
	logic        flag_r;
	logic [6:0]  flag_rsv_r;
	logic [IRQ_W_C-1:0] irq_stat_r;
	logic [IRQ_W_C-1:0] irq_en_r;
	logic [2:0]  eoc_sync_r;
	logic        eoc_r;
	logic        ack_r;
	logic [31:0] rdata_nxt;
	logic        wr_cfg;
	logic        wr_conv;
	logic        wr_temp;
	logic        wr_data;
	logic        wr_flag;
	logic        wr_touch;
	logic        wr_en;
	logic        wr_clr;
	logic        req;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		hit = (a == b);
	endfunction

	acc_seq u_seq (
		.clk_i         (clk_i),
		.rst_i         (rst_i),
		.cif           (cif),
		.core_result_i (core_result_i),
		.core_sample_o (core_sample_o),
		.core_tick_o   (core_tick_o)
	);

	assign cif.start   = start_r;
	assign cif.power   = cfg_r[acc_pkg::CFG_PWR];
	assign cif.div_sel = cfg_r[acc_pkg::CFG_DIV_HI:acc_pkg::CFG_DIV_LO];

	// Wishbone classic: one wait state, ack drops after one cycle
	assign req      = wb_cyc_i && wb_stb_i && !ack_r;
	assign wr_cfg   = req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, acc_pkg::ADDR_CFG);
	assign wr_conv  = req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, acc_pkg::ADDR_CONVERT);
	assign wr_temp  = req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, acc_pkg::ADDR_TEMP);
	assign wr_data  = req && wb_we_i && wb_sel_i[1] && hit(wb_adr_i, acc_pkg::ADDR_DATA);
	assign wr_flag  = req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, acc_pkg::ADDR_FLAG);
	assign wr_touch = req && wb_we_i && hit(wb_adr_i, acc_pkg::ADDR_TOUCH);
	assign wr_en    = req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, acc_pkg::ADDR_IRQ_EN);
	assign wr_clr   = req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, acc_pkg::ADDR_IRQ_CLR);

	always_ff @(posedge clk_i) begin
		if (rst_i)
			ack_r <= 1'b0;
		else
			ack_r <= req;
	end
	assign wb_ack_o = ack_r;

	// Configuration register
	always_ff @(posedge clk_i) begin
		if (rst_i)
			cfg_r <= acc_pkg::CFG_RESET;
		else if (wr_cfg)
			cfg_r <= wb_dat_i[7:0];
	end
	assign front_end_gain_select_o = cfg_r[acc_pkg::CFG_GAIN_HI:acc_pkg::CFG_GAIN_LO];
	assign differential_input_enable_o = cfg_r[acc_pkg::CFG_DIFF];
	assign input_buffer_enable_o = cfg_r[acc_pkg::CFG_BUF];
	assign converter_power_enable_o = cfg_r[acc_pkg::CFG_PWR];

	// Start bit: completion clears it; a write of one in that same cycle wins
	always_ff @(posedge clk_i) begin
		if (rst_i)
			start_r <= 1'b0;
		else if (wr_conv && wb_dat_i[acc_pkg::CONV_GO])
			start_r <= 1'b1;
		else if (cif.done || (wr_conv && !wb_dat_i[acc_pkg::CONV_GO]))
			start_r <= 1'b0;
		else if (!cif.busy && start_r && !cif.power)
			start_r <= 1'b0;
	end

	// Asynchronous end flag: three stages, change counts once last two agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			eoc_sync_r <= '0;
			eoc_r      <= 1'b0;
		end else begin
			eoc_sync_r <= {eoc_sync_r[1:0], core_eoc_async_i};
			if (eoc_sync_r[1] == eoc_sync_r[2])
				eoc_r <= eoc_sync_r[2];
		end
	end

	// Temperature sensor power and its reserved read-write bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			temp_pwr_r <= 1'b0;
			temp_rsv_r <= '0;
		end else if (wr_temp) begin
			temp_pwr_r <= wb_dat_i[acc_pkg::TEMP_PWR];
			temp_rsv_r <= wb_dat_i[6:0];
		end
	end
	assign temp_sensor_power_enable_o = temp_pwr_r;

	// Result register, inversion applied at capture in offset test mode
	always_ff @(posedge clk_i) begin
		if (rst_i)
			result_r <= '0;
		else if (cif.done) begin
			if (cfg_r[acc_pkg::CFG_OFS])
				result_r <= cif.result ^ acc_pkg::RES_INV_MASK;
			else
				result_r <= cif.result;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			data_rsv_r <= '0;
		else if (wr_data)
			data_rsv_r <= wb_dat_i[15:12];
	end

	// Finished flag: completion wins over a clearing write in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i)
			flag_r <= 1'b0;
		else if (cif.done)
			flag_r <= 1'b1;
		else if (wr_conv || wr_touch)
			flag_r <= 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			flag_rsv_r <= '0;
		else if (wr_flag)
			flag_rsv_r <= wb_dat_i[6:0];
	end

	// Sticky interrupt status, write-one clear, set wins
	always_ff @(posedge clk_i) begin
		if (rst_i)
			irq_stat_r <= '0;
		else
			irq_stat_r <= (irq_stat_r & ~(wr_clr ? wb_dat_i[IRQ_W_C-1:0] : '0))
				| {cif.done};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			irq_en_r <= '0;
		else if (wr_en)
			irq_en_r <= wb_dat_i[IRQ_W_C-1:0];
	end
	assign irq_o = |(irq_stat_r & irq_en_r);

	// Read data registered with the ack; unmapped reads return zero
	always_comb begin
		rdata_nxt = '0;
		case (wb_adr_i)
			acc_pkg::ADDR_CFG:      rdata_nxt[7:0] = cfg_r;
			acc_pkg::ADDR_CONVERT: begin
				rdata_nxt[acc_pkg::CONV_EOC] = eoc_r;
				rdata_nxt[acc_pkg::CONV_GO]  = start_r;
			end
			acc_pkg::ADDR_TEMP:     rdata_nxt[7:0] = {temp_pwr_r, temp_rsv_r};
			acc_pkg::ADDR_DATA:     rdata_nxt[15:0] = {data_rsv_r, result_r};
			acc_pkg::ADDR_FLAG:     rdata_nxt[7:0] = {flag_r, flag_rsv_r};
			acc_pkg::ADDR_IRQ_STAT: rdata_nxt[IRQ_W_C-1:0] = irq_stat_r;
			acc_pkg::ADDR_IRQ_EN:   rdata_nxt[IRQ_W_C-1:0] = irq_en_r;
			default:                rdata_nxt = '0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			wb_dat_o <= '0;
		else if (req && !wb_we_i)
			wb_dat_o <= rdata_nxt;
	end

	// Channel selection sits in another block; touch and
	// buffer advice is left to software.
endmodule
`default_nettype wire

// File: tb/acc_core_model.sv
// Behavioural analog converter core: fixed result, busy level while converting
`timescale 1ns/1ps
`default_nettype none
module acc_core_model #(
	parameter logic [11:0] RESULT = 12'h573
) (
	input  wire logic        clk_i,
	input  wire logic        sample_i,
	input  wire logic        tick_i,
	output logic             eoc_o,
	output logic [11:0]      result_o
);
	logic [4:0] n;
	initial begin
		eoc_o = 1'b1;
		n = 5'h00;
	end
	// Result line is held steady; the design samples it on its last converter clock
	assign result_o = RESULT;
	always @(posedge clk_i) begin
		if (sample_i && eoc_o) begin
			eoc_o <= 1'b0;
			n <= tick_i ? 5'h01 : 5'h00; // A clock in the first sampling cycle counts too
		end else if (!eoc_o && tick_i) begin
			n <= n + 5'h01;
			if (n == 5'h10) eoc_o <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: tb/acc_top_props.sv
// Checker: bus handshake and control output properties
`timescale 1ns/1ps
`default_nettype none
module acc_top_props (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        core_sample_o,
	input wire logic [1:0]  front_end_gain_select_o,
	input wire logic        differential_input_enable_o,
	input wire logic        input_buffer_enable_o,
	input wire logic        converter_power_enable_o,
	input wire logic        temp_sensor_power_enable_o,
	input wire logic        irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence wr_s(logic [7:0] a);
		wb_ack_o && wb_we_i && wb_adr_i == a && wb_sel_i[0];
	endsequence
	sequence rd_s(logic [7:0] a);
		wb_ack_o && !wb_we_i && wb_adr_i == a;
	endsequence
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_delay_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack not one cycle after request");
	ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	cfg_write_a: assert property (wr_s(acc_pkg::ADDR_CFG) |=>
		{front_end_gain_select_o, differential_input_enable_o, input_buffer_enable_o,
		converter_power_enable_o} == {$past(wb_dat_i[5:4]), $past(wb_dat_i[2:0])})
		else $error("config outputs differ from written value");
	temp_write_a: assert property (wr_s(acc_pkg::ADDR_TEMP) |=>
		temp_sensor_power_enable_o == $past(wb_dat_i[7])) else $error("sensor power wrong");
	reset_vals_a: assert property (disable iff (1'b0) rst_i |=>
		front_end_gain_select_o == 2'h2 && !converter_power_enable_o && !irq_o)
		else $error("reset values wrong");
	no_power_a: assert property ($rose(core_sample_o) |-> converter_power_enable_o)
		else $error("sampling while powered down");
	busy_read_a: assert property (rd_s(acc_pkg::ADDR_CONVERT) ##0 $past(core_sample_o)
		|-> wb_dat_o[0]) else $error("start bit low during sampling");
	unmapped_a: assert property (rd_s(8'h24) |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
endmodule
bind acc_top acc_top_props acc_top_props_inst (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.core_sample_o(core_sample_o), .front_end_gain_select_o(front_end_gain_select_o),
	.differential_input_enable_o(differential_input_enable_o),
	.input_buffer_enable_o(input_buffer_enable_o),
	.converter_power_enable_o(converter_power_enable_o),
	.temp_sensor_power_enable_o(temp_sensor_power_enable_o), .irq_o(irq_o));
`default_nettype wire

// File: tb/acc_top_tb_top.sv
// Testbench: register access, conversions, interrupt and power-off behaviour
`timescale 1ns/1ps
`default_nettype none
module acc_top_tb_top;
	logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wd = 32'h0, rd;
	logic ack, eoc, smp, tck, dif, buf_en, pwr, tsp, irq;
	logic [11:0] res;
	logic [1:0] gain;
	logic [3:0] sel = 4'hf;
	int bad_count = 0, samples_checked = 0, cyc_n = 0;
	always #4 clk = ~clk;
	always @(posedge clk) cyc_n <= cyc_n + 1;
	acc_top acc_top_inst (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd),
		.wb_ack_o(ack), .core_eoc_async_i(eoc), .core_result_i(res), .core_sample_o(smp),
		.core_tick_o(tck), .front_end_gain_select_o(gain), .differential_input_enable_o(dif),
		.input_buffer_enable_o(buf_en), .converter_power_enable_o(pwr),
		.temp_sensor_power_enable_o(tsp), .irq_o(irq));
	acc_core_model acc_core_model_inst (.clk_i(clk), .sample_i(smp), .tick_i(tck),
		.eoc_o(eoc), .result_o(res));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		adr <= a;
		we <= w;
		wd <= d;
		cyc <= 1'b1;
		stb <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) chk("ack", 1, 0);
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic t_reset;
		logic [31:0] q;
		bus(acc_pkg::ADDR_CFG, 0, 0, q); chk("cfg", 32'ha0, q);
		// Idle core reports completed, so the end flag is up once synchronised
		bus(acc_pkg::ADDR_CONVERT, 0, 0, q); chk("conv", 32'h80, q);
		bus(acc_pkg::ADDR_FLAG, 0, 0, q); chk("flag", 32'h0, q);
		bus(8'h24, 0, 0, q); chk("unmapped", 32'h0, q);
	endtask
	task automatic t_regs;
		logic [31:0] q, v;
		for (int i = 0; i < 4; i++) begin
			v = 32'(i * 16 + i + 1); // Code 4 is differential with buffer off
			bus(acc_pkg::ADDR_CFG, 1, v, q);
			bus(acc_pkg::ADDR_CFG, 0, 0, q); chk("cfg rb", v, q);
			chk("cfg out", {v[5:4], v[2:0]}, {gain, dif, buf_en, pwr});
		end
		sel <= 4'he; // Byte lane 0 off: configuration must not change
		bus(acc_pkg::ADDR_CFG, 1, 32'hff, q);
		sel <= 4'hf;
		bus(acc_pkg::ADDR_CFG, 0, 0, q); chk("cfg sel", 32'h34, q);
		bus(acc_pkg::ADDR_TEMP, 1, 32'hff, q);
		bus(acc_pkg::ADDR_TEMP, 0, 0, q); chk("temp", 32'hff, q);
		chk("tsp", 1, tsp);
	endtask
	task automatic t_conv(input logic [1:0] code, input logic ofs);
		logic [31:0] q;
		int t0, d, dv;
		dv = code == 2'h0 ? 10 : code == 2'h1 ? 4 : code == 2'h2 ? 6 : 8;
		d = 17 * dv * 125 / 32;
		bus(acc_pkg::ADDR_IRQ_EN, 1, 1, q);
		bus(acc_pkg::ADDR_DATA, 1, 32'h5000, q);
		bus(acc_pkg::ADDR_CFG, 1, {24'h0, code, 2'h2, ofs, 3'h3}, q);
		bus(acc_pkg::ADDR_CONVERT, 1, 1, q);
		t0 = cyc_n;
		bus(acc_pkg::ADDR_CONVERT, 0, 0, q); chk("start", 1, q & 1);
		// Wait out the three-stage synchroniser before looking at the end flag
		repeat (4) @(posedge clk);
		bus(acc_pkg::ADDR_CONVERT, 0, 0, q); chk("busy eoc", 32'h01, q);
		do bus(acc_pkg::ADDR_CONVERT, 0, 0, q); while (q[0] && cyc_n - t0 < 3000);
		t0 = cyc_n - t0;
		// Divider runs free, so the first converter clock may come up to one period early
		chk("conv time", 1, 32'(t0 > d - dv * 125 / 32 - 10 && t0 < d + 55));
		bus(acc_pkg::ADDR_DATA, 0, 0, q);
		chk("data", {20'h5, ofs ? 12'ha8c : 12'h573}, q);
		bus(acc_pkg::ADDR_CONVERT, 0, 0, q); chk("eoc", 32'h80, q);
		bus(acc_pkg::ADDR_FLAG, 0, 0, q); chk("flag", 32'h80, q);
		chk("irq", 1, irq);
		bus(acc_pkg::ADDR_IRQ_EN, 1, 0, q); chk("irq masked", 0, irq);
		bus(acc_pkg::ADDR_IRQ_EN, 1, 1, q); chk("irq again", 1, irq);
		bus(acc_pkg::ADDR_IRQ_CLR, 1, 1, q); chk("irq clr", 0, irq);
		bus(ofs ? acc_pkg::ADDR_TOUCH : acc_pkg::ADDR_CONVERT, 1, 0, q);
		bus(acc_pkg::ADDR_FLAG, 0, 0, q); chk("flag clr", 32'h0, q);
	endtask
	task automatic t_nopwr;
		logic [31:0] q;
		bus(acc_pkg::ADDR_CFG, 1, 32'ha2, q);
		bus(acc_pkg::ADDR_CONVERT, 1, 1, q);
		repeat (100) @(posedge clk);
		bus(acc_pkg::ADDR_CONVERT, 0, 0, q); chk("no start", 0, q[0]);
		bus(acc_pkg::ADDR_FLAG, 0, 0, q); chk("no flag", 0, q);
	endtask
	task automatic final_report;
		$display("Comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_regs();
		for (int c = 0; c < 4; c++) t_conv(2'(c), c[0]);
		t_nopwr();
		final_report();
	end
	// Four conversions at most about 700 cycles each plus register traffic
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		final_report();
	end
endmodule
`default_nettype wire
